// >>> hw/iam_slave.sv
// Two-wire slave with masked address match, reserved filter, registers and receive FIFO
// How it works
// - A mask bit set to one lets that received address bit take either value.
// - Masking applies only while the accept-all-addresses bit (bit 11) is clear.
// - Reserved addresses other than the ten-bit header are never matched or acknowledged, whatever the mask.
// - The all-zero write address is acknowledged only with broadcast call enabled.
// - The 1111 0xx pattern matches only as the upper byte in ten-bit mode.
// - The baud reload register holds the master clock divider; 157, 37, 13 are guides.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module iam_slave (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic pins_to_module
);
    // Pin synchronisers: a change counts once stages two and three agree
    iam_pkg::iam_line_s s1_q, s2_q, s3_q, line_q, prev_q, line_d;

    always_comb begin
        line_d = line_q;
        if (s2_q == s3_q) begin
            line_d = s3_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            line_q <= '1;
            prev_q <= '1;
        end else if (ce) begin
            s1_q <= {scl_i, sda_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
            line_q <= line_d;
            prev_q <= line_q;
        end
    end

    logic rise, fall, start_c, stop_c;
    assign rise = line_q.scl && !prev_q.scl;
    assign fall = !line_q.scl && prev_q.scl;
    assign start_c = line_q.scl && prev_q.scl && prev_q.sda && !line_q.sda;
    assign stop_c = line_q.scl && prev_q.scl && !prev_q.sda && line_q.sda;

    // Registers
    logic [15:0] ctrl_q, ctrl_d;
    logic [9:0] own_q, own_d, mask_q, mask_d;
    logic [8:0] baud_q, baud_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic [2:0] clr_flags;
    logic pop;

    // Receive FIFO
    logic push, fifo_ready, fifo_valid;
    logic [7:0] fifo_dout;
    logic [4:0] fifo_lvl;
    logic [7:0] sh_q, sh_d;

    iam_fifo #(.W(iam_pkg::DATA_W), .D(iam_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(sh_q),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_dout),
        .level(fifo_lvl)
    );

    // Slave state
    iam_pkg::iam_state_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic drv_q, drv_d;
    iam_pkg::iam_flags_s fl_q, fl_d;
    logic on, tenbit, all_addr, broadcast_call_enable, decide;
    logic [9:0] mask_eff;
    logic res7, gc7, m7, hdr_ok, m_lo;

    assign on = ctrl_q[iam_pkg::CTL_ON];
    assign tenbit = ctrl_q[iam_pkg::CTL_TENBIT];
    assign all_addr = ctrl_q[iam_pkg::CTL_ALLADDR];
    assign broadcast_call_enable = ctrl_q[iam_pkg::CTL_BROADCAST_CALL_ENABLE];
    assign mask_eff = all_addr ? '1 : mask_q;
    assign decide = fall && cnt_q == iam_pkg::BIT_ACK;
    assign res7 = iam_pkg::reserved7(sh_q[7:1], sh_q[0]);
    assign gc7 = sh_q == 8'h00 && broadcast_call_enable;
    assign m7 = iam_pkg::mask_match({1'b0, sh_q[7:1]}, {1'b0, own_q[6:0]},
                                    {1'b1, mask_eff[6:0]});
    assign hdr_ok = tenbit && !sh_q[0] && sh_q[7:3] == iam_pkg::HDR_10BIT
                    && iam_pkg::mask_match({6'h00, sh_q[2:1]}, {6'h00, own_q[9:8]},
                                           {6'h3f, mask_eff[9:8]});
    assign m_lo = iam_pkg::mask_match(sh_q, own_q[7:0], mask_eff[7:0]);
    assign push = decide && st_q == iam_pkg::ST_DATA && on;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        drv_d = drv_q;
        fl_d = fl_q;
        if (clr_flags[0]) fl_d.hit = 1'b0;
        if (clr_flags[1]) fl_d.gcall = 1'b0;
        if (clr_flags[2]) fl_d.ovf = 1'b0;
        if (!on) begin
            st_d = iam_pkg::ST_IDLE;
            drv_d = 1'b0;
        end else if (stop_c) begin
            st_d = iam_pkg::ST_IDLE;
            drv_d = 1'b0;
        end else if (start_c) begin
            st_d = iam_pkg::ST_ADDR;
            cnt_d = '0;
            drv_d = 1'b0;
        end else if (st_q != iam_pkg::ST_IDLE) begin
            if (rise && cnt_q < iam_pkg::BIT_END) begin
                if (cnt_q < iam_pkg::BIT_ACK) begin
                    sh_d = {sh_q[6:0], line_q.sda};
                end
                cnt_d = 4'(cnt_q + 1'b1);
            end
            if (fall && cnt_q == iam_pkg::BIT_END) begin
                drv_d = 1'b0;
                cnt_d = '0;
            end
            if (decide) begin
                unique case (st_q)
                    iam_pkg::ST_ADDR: begin
                        if (gc7) begin
                            drv_d = 1'b1;
                            fl_d.gcall = 1'b1;
                            st_d = iam_pkg::ST_DATA;
                        end else if (hdr_ok) begin
                            drv_d = 1'b1;
                            st_d = iam_pkg::ST_ADDR2;
                        end else if (!tenbit && !res7 && sh_q != 8'h00 && m7) begin
                            drv_d = 1'b1;
                            fl_d.hit = 1'b1;
                            st_d = sh_q[0] ? iam_pkg::ST_SKIP : iam_pkg::ST_DATA;
                        end else begin
                            st_d = iam_pkg::ST_SKIP;
                        end
                    end
                    iam_pkg::ST_ADDR2: begin
                        drv_d = m_lo;
                        if (m_lo) fl_d.hit = 1'b1;
                        st_d = m_lo ? iam_pkg::ST_DATA : iam_pkg::ST_SKIP;
                    end
                    iam_pkg::ST_DATA: begin
                        drv_d = fifo_ready;
                        if (!fifo_ready) fl_d.ovf = 1'b1;
                    end
                    iam_pkg::ST_SKIP: begin
                        drv_d = 1'b0;
                    end
                    iam_pkg::ST_IDLE: begin
                        drv_d = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= iam_pkg::ST_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            drv_q <= 1'b0;
            fl_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            drv_q <= drv_d;
            fl_q <= fl_d;
        end
    end

    // Open-drain pins: only the data line is ever pulled low, to acknowledge
    assign sda_o = 1'b0;
    assign sda_oe_n = !(drv_q && on);
    assign scl_o = 1'b0;
    assign scl_oe_n = 1'b1;
    assign pins_to_module = on;

    // Wishbone slave: ack one cycle after the request, unmapped reads give zero
    logic req, wr;
    logic [31:0] stat;
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i;
    assign pop = req && !wb_we_i && wb_adr_i == iam_pkg::OFS_RXDATA && fifo_valid;
    assign stat = {19'h0, fifo_lvl, 2'h0, st_q != iam_pkg::ST_IDLE, !fifo_ready,
                   !fifo_valid, fl_q.ovf, fl_q.gcall, fl_q.hit};

    always_comb begin
        ctrl_d = ctrl_q & ~iam_pkg::CTL_HC_MASK;
        own_d = own_q;
        mask_d = mask_q;
        baud_d = baud_q;
        clr_flags = 3'h0;
        ack_d = req;
        dat_d = dat_q;
        if (wr) begin
            unique case (wb_adr_i)
                iam_pkg::OFS_CTRL: ctrl_d = 16'(iam_pkg::apply_sel({16'h0, ctrl_q},
                                                 wb_dat_i, wb_sel_i)) & iam_pkg::CTL_WMASK;
                iam_pkg::OFS_OWN: own_d = 10'(iam_pkg::apply_sel({22'h0, own_q},
                                                 wb_dat_i, wb_sel_i));
                iam_pkg::OFS_MASK: mask_d = 10'(iam_pkg::apply_sel({22'h0, mask_q},
                                                 wb_dat_i, wb_sel_i));
                iam_pkg::OFS_BAUD: baud_d = 9'(iam_pkg::apply_sel({23'h0, baud_q},
                                                 wb_dat_i, wb_sel_i));
                iam_pkg::OFS_STAT: clr_flags = wb_sel_i[0] ? wb_dat_i[2:0] : 3'h0;
                default: ;
            endcase
        end else if (req) begin
            unique case (wb_adr_i)
                iam_pkg::OFS_CTRL: dat_d = {16'h0, ctrl_q};
                iam_pkg::OFS_OWN: dat_d = {22'h0, own_q};
                iam_pkg::OFS_MASK: dat_d = {22'h0, mask_q};
                iam_pkg::OFS_BAUD: dat_d = {23'h0, baud_q};
                iam_pkg::OFS_STAT: dat_d = stat;
                iam_pkg::OFS_RXDATA: dat_d = fifo_valid ? {24'h0, fifo_dout} : 32'h0;
                default: dat_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= iam_pkg::CTL_RESET;
            own_q <= iam_pkg::OWN_RESET;
            mask_q <= iam_pkg::MASK_RESET;
            baud_q <= iam_pkg::BAUD_RESET;
            ack_q <= 1'b0;
            dat_q <= '0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            own_q <= own_d;
            mask_q <= mask_d;
            baud_q <= baud_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_off_pins_free: assert property (ce && !on |-> sda_oe_n && !pins_to_module ##1 !drv_q)
        else $error("Pins held while module off");
    a_reserved_no_ack: assert property (ce && on && decide && st_q == iam_pkg::ST_ADDR
        && res7 && sh_q != 8'h00 && (!tenbit || sh_q[7:3] != iam_pkg::HDR_10BIT)
        |=> !drv_q)
        else $error("Reserved address acknowledged");
    a_gcall_gated: assert property (ce && on && decide && st_q == iam_pkg::ST_ADDR
        && sh_q == 8'h00 && !broadcast_call_enable |=> !drv_q)
        else $error("General call acknowledged while disabled");
    a_hdr_not_seven: assert property (ce && on && decide && st_q == iam_pkg::ST_ADDR
        && !tenbit && sh_q[7:3] == iam_pkg::HDR_10BIT |=> !drv_q)
        else $error("Ten-bit header matched as seven-bit");
    a_mask_hit_ack: assert property (ce && on && decide && st_q == iam_pkg::ST_ADDR
        && !start_c && !stop_c && !tenbit && !res7 && !all_addr
        && (sh_q != 8'h00 || broadcast_call_enable)
        && (((sh_q[7:1] ^ own_q[6:0]) & ~mask_q[6:0]) == 7'h00)
        |=> drv_q ##1 (drv_q || !ce))
        else $error("Masked match not acknowledged");
    a_all_addr_ack: assert property (ce && on && decide && st_q == iam_pkg::ST_ADDR
        && !start_c && !stop_c && !tenbit && !res7 && all_addr
        && (sh_q != 8'h00 || broadcast_call_enable) |=> drv_q)
        else $error("Accept-all mode missed an address");
    a_baud_stable: assert property (ce && !(wr && wb_adr_i == iam_pkg::OFS_BAUD)
        |=> $stable(baud_q))
        else $error("Baud reload changed without a write");
    a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Bus ack held two cycles");
endmodule

// >>> hw/iam_pkg.sv
// Shared constants, types and helpers for the two-wire address match block
package iam_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned CNT_W = 5;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OWN = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_BAUD = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_RXDATA = 8'h14;

    // bus_control field positions
    localparam int CTL_ON = 15;
    localparam int CTL_CLOCK_LINE_RELEASE = 12;
    localparam int CTL_ALLADDR = 11;
    localparam int CTL_TENBIT = 10;
    localparam int CTL_BROADCAST_CALL_ENABLE = 7;
    localparam logic [15:0] CTL_RESET = 16'h1000;
    localparam logic [15:0] CTL_WMASK = 16'hbfff;
    localparam logic [15:0] CTL_HC_MASK = 16'h001f;

    localparam int unsigned ADDR10_W = 10;
    localparam logic [9:0] OWN_RESET = 10'h000;
    localparam logic [9:0] MASK_RESET = 10'h000;

    // Baud reload register and guidance values for a 16 MHz instruction clock
    localparam int unsigned BAUD_W = 9;
    localparam logic [8:0] BAUD_RESET = 9'h000;
    localparam logic [8:0] BAUD_100K = 9'h09d;
    localparam logic [8:0] BAUD_400K = 9'h025;
    localparam logic [8:0] BAUD_1M = 9'h00d;

    // Status field positions
    localparam int STAT_HIT = 0;
    localparam int STAT_GCALL = 1;
    localparam int STAT_OVF = 2;
    localparam int STAT_EMPTY = 3;
    localparam int STAT_FULL = 4;
    localparam int STAT_BUSY = 5;
    localparam int STAT_LVL = 8;

    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    localparam logic [4:0] HDR_10BIT = 5'h1e;
    localparam logic [4:0] RES_HIGH = 5'h1f;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_ADDR2 = 5'h04,
        ST_DATA = 5'h08,
        ST_SKIP = 5'h10
    } iam_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } iam_line_s;

    typedef struct packed {
        logic ovf;
        logic gcall;
        logic hit;
    } iam_flags_s;

    // Every bit equal or masked out
    function automatic logic mask_match(input logic [7:0] rx, input logic [7:0] own,
                                        input logic [7:0] msk);
        mask_match = &(~(rx ^ own) | msk);
    endfunction

    // Addresses never matched as a 7-bit address (general call handled apart)
    function automatic logic reserved7(input logic [6:0] a, input logic rw);
        reserved7 = (a[6:3] == 4'h0 && !(a == 7'h00 && !rw)) || a[6:2] == RES_HIGH
                    || a[6:2] == HDR_10BIT;
    endfunction

    function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                old[8*i +: 8] = nw[8*i +: 8];
            end
        end
        apply_sel = old;
    endfunction
endpackage

// >>> hw/iam_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module iam_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [W-1:0] mem_d [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d = AW'(wr_q + 1'b1);
        end
        if (pop) begin
            rd_d = AW'(rd_q + 1'b1);
        end
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < D; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_fifo_full_block: assert property (cnt_q == (AW+1)'(D) |-> !in_ready)
        else $error("FIFO ready while full");
    a_fifo_level_up: assert property (ce && push && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("FIFO level did not rise on push");
endmodule

// >>> sim/iam_link_master.sv
// Behavioural two-wire bus master that drives the far side of the slave
`timescale 1ns/1ps
module iam_link_master (
    output logic scl_drv,
    output logic sda_drv,
    input wire logic sda_line
);
    // Clock stands high and data is released between frames
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // Frame events sit off the system clock edges
    task automatic start_cond();
        #5;
        sda_drv = 1'b0;
        #100;
        scl_drv = 1'b0;
    endtask

    task automatic stop_cond();
        #50;
        sda_drv = 1'b0;
        #50;
        scl_drv = 1'b1;
        #100;
        sda_drv = 1'b1;
        #100;
    endtask

    // MSB first, then an ACK slot sampled late in the ninth high phase
    task automatic send_byte(input logic [7:0] b, output logic ack);
        #100;
        for (int i = 7; i >= 0; i--) begin
            #50;
            sda_drv = b[i];
            #50;
            scl_drv = 1'b1;
            #100;
            scl_drv = 1'b0;
        end
        // Long low phase so the slave's acknowledge settles before the clock rises
        #50;
        sda_drv = 1'b1;
        #150;
        scl_drv = 1'b1;
        #90;
        ack = ~sda_line;
        #10;
        scl_drv = 1'b0;
    endtask
endmodule

// >>> sim/tb_iam_slave.sv
// Self-checking bench for the two-wire address match slave
`timescale 1ns/1ps
module tb_iam_slave;
    localparam int LIMIT = 20000;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, pins_to_module;
    logic m_scl, m_sda;
    logic scl_line, sda_line;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    // Open-drain wires with pull-ups
    assign scl_line = m_scl & (scl_oe_n | scl_o);
    assign sda_line = m_sda & (sda_oe_n | sda_o);

    iam_slave dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .pins_to_module(pins_to_module)
    );

    iam_link_master mdl_u (.scl_drv(m_scl), .sda_drv(m_sda), .sda_line(sda_line));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic single cycle: hold until ack is sampled, then one idle cycle
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        rd = wb_dat_o;
        if (n >= 100) begin
            err_count++;
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] rd;
        wb_xfer(1'b1, adr, dat, rd);
    endtask

    task automatic wb_rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_xfer(1'b0, adr, 32'h0, rd);
        check(rd, exp);
    endtask

    // One address frame with the given control and mask settings
    task automatic try_addr(input logic [31:0] ctrl, input logic [31:0] msk,
                            input logic [7:0] b, input logic exp);
        logic ack;
        wb_wr(iam_pkg::OFS_CTRL, ctrl);
        wb_wr(iam_pkg::OFS_MASK, msk);
        mdl_u.start_cond();
        mdl_u.send_byte(b, ack);
        mdl_u.stop_cond();
        check({31'h0, ack}, {31'h0, exp});
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        logic ack;
        logic [31:0] rd;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check({31'h0, pins_to_module}, 32'h0);
        wb_rd_chk(iam_pkg::OFS_CTRL, 32'h1000);
        wb_rd_chk(iam_pkg::OFS_BAUD, 32'h0);
        wb_rd_chk(8'h3c, 32'h0);
        wb_wr(iam_pkg::OFS_BAUD, 32'h9d);
        wb_rd_chk(iam_pkg::OFS_BAUD, 32'h9d);
        wb_wr(iam_pkg::OFS_BAUD, 32'h25);
        wb_rd_chk(iam_pkg::OFS_BAUD, 32'h25);
        wb_wr(iam_pkg::OFS_BAUD, 32'h0d);
        wb_rd_chk(iam_pkg::OFS_BAUD, 32'h0d);
        wb_wr(iam_pkg::OFS_OWN, 32'h50);
        try_addr(32'h1000, 32'h0, 8'ha0, 1'b0);
        try_addr(32'h9000, 32'h0, 8'ha0, 1'b1);
        check({31'h0, pins_to_module}, 32'h1);
        try_addr(32'h9000, 32'h0, 8'ha2, 1'b0);
        try_addr(32'h9000, 32'h20, 8'he0, 1'b1);
        try_addr(32'h9000, 32'h20, 8'he2, 1'b0);
        try_addr(32'h9800, 32'h0, 8'he2, 1'b1);
        try_addr(32'h9000, 32'h7f, 8'h2a, 1'b1);
        try_addr(32'h9000, 32'h7f, 8'h01, 1'b0);
        try_addr(32'h9000, 32'h7f, 8'h02, 1'b0);
        try_addr(32'h9000, 32'h7f, 8'h04, 1'b0);
        try_addr(32'h9000, 32'h7f, 8'h07, 1'b0);
        try_addr(32'h9000, 32'h7f, 8'h0a, 1'b0);
        try_addr(32'h9000, 32'h7f, 8'hfa, 1'b0);
        try_addr(32'h9000, 32'h7f, 8'hf4, 1'b0);
        try_addr(32'h9000, 32'h7f, 8'h00, 1'b0);
        try_addr(32'h9080, 32'h0, 8'h00, 1'b1);
        // Ten-bit header then low address byte
        wb_wr(iam_pkg::OFS_OWN, 32'h2a5);
        wb_wr(iam_pkg::OFS_CTRL, 32'h9400);
        mdl_u.start_cond();
        mdl_u.send_byte(8'hf4, ack);
        check({31'h0, ack}, 32'h1);
        mdl_u.send_byte(8'ha5, ack);
        check({31'h0, ack}, 32'h1);
        mdl_u.stop_cond();
        // Fill the receive buffer until it refuses, then drain it
        wb_wr(iam_pkg::OFS_OWN, 32'h50);
        wb_wr(iam_pkg::OFS_CTRL, 32'h9000);
        mdl_u.start_cond();
        mdl_u.send_byte(8'ha0, ack);
        check({31'h0, ack}, 32'h1);
        for (int i = 0; i < 17; i++) begin
            mdl_u.send_byte(8'h30 + i[7:0], ack);
            check({31'h0, ack}, {31'h0, i < 16});
        end
        mdl_u.stop_cond();
        wb_xfer(1'b0, iam_pkg::OFS_STAT, 32'h0, rd);
        check(rd & 32'h1f1c, 32'h1014);
        for (int i = 0; i < 16; i++) begin
            wb_rd_chk(iam_pkg::OFS_RXDATA, {24'h0, 8'h30 + i[7:0]});
        end
        wb_xfer(1'b0, iam_pkg::OFS_STAT, 32'h0, rd);
        check(rd & 32'h1f18, 32'h0008);
        wb_rd_chk(iam_pkg::OFS_RXDATA, 32'h0);
        // Sticky flags clear on a write of ones
        wb_wr(iam_pkg::OFS_STAT, 32'h7);
        wb_rd_chk(iam_pkg::OFS_STAT, 32'h8);
        report_and_stop();
    end
endmodule
